/* File: design/reset_lowpower_mode_control.sv */
/*
 * Reset, clock entry and low-power mode control for an 8-bit
 * microcontroller: reset qualification, external-access latch, idle and
 * power-down sequencing, pin hold states and code-read protection.
 * Assumes the core reports instruction completion and wake interrupts
 * on sys_clk, and that the reset pin arrives asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rst_lp_defs.svh"

module reset_lowpower_mode_control #(
	parameter logic CODE_PROTECT = 1'b0,
	parameter int   PC_WIDTH     = 16
) (
	input  wire logic                sys_clk,           // oscillator clock
	input  wire logic                rst_b,             // sync reset, low
	input  wire logic                rst_pin_in,        // reset pin level
	output logic                     rst_pin_out,       // reset pin drive
	output logic                     rst_pin_oe,        // reset pin enable
	input  wire logic                ext_access_in,     // access select pin
	input  wire logic [7:0]          power_control_register, // mode bits
	input  wire logic                instr_done,        // instruction retired
	input  wire logic                irq_pending,       // enabled interrupt
	input  wire logic                watchdog_overflow, // watchdog pulse
	input  wire logic [PC_WIDTH-1:0] pc,                // program counter
	input  wire logic                code_read_instr,   // code read cycle
	input  wire logic                fetch_external,    // executing outside
	input  wire logic                test_read_req,     // test-mode readout
	input  wire logic                core_ale,          // core strobe
	input  wire logic                core_program_store_strobe,         // core strobe
	input  wire logic                core_pwm0,         // core pwm level
	input  wire logic                core_pwm1,         // core pwm level
	output logic                     core_reset,        // core reset level
	output logic                     cpu_run,           // core clock gate
	output logic                     periph_run,        // peripheral gate
	output logic                     osc_run,           // oscillator enable
	output logic                     phase_clk,         // divided phase
	output logic                     external_access_select, // latched
	output logic                     fetch_internal,    // internal fetch
	output logic                     code_read_allow,   // code as data ok
	output logic                     readout_refused,   // readout blocked
	output logic                     irq_vector_take,   // wake to handler
	output logic                     address_latch_strobe, // pin level
	output logic                     program_store_strobe, // pin level
	output logic                     port0_oe,          // port 0 enable
	output logic                     port0_hold,        // freeze data
	output logic                     port2_addr_sel,    // port 2 address
	output logic                     pulse_width_out0,  // pwm pin
	output logic                     pulse_width_out1,  // pwm pin
	output rst_lp_pkg::lp_mode_t     mode               // present mode
);
	rst_lp_pkg::lp_mode_t mode_r;
	rst_lp_pkg::lp_mode_t mode_nxt;
	logic                 ea_sync1_r;
	logic                 ea_sync2_r;
	logic                 ea_latch_r;
	logic [4:0]           wdt_cnt_r;
	logic [4:0]           wdt_cnt_nxt;
	wire                  mcycle_end;
	wire                  rst_valid;
	wire                  phase_w;
	wire                  in_reset;
	wire                  idle_req;
	wire                  pdown_req;
	wire                  low_power;
	wire                  pc_internal;
	wire                  wdt_active;
	logic                 pin_sync1_r;
	logic                 pin_sync2_r;
	wire                  osc_on;

	osc_half_divider #(
		.PER_MCYCLE (`OSC_PER_MCYCLE)
	) osc_half_divider_inst (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.osc_run    (osc_on),
		.phase_clk  (phase_w),
		.mcycle_end (mcycle_end)
	);

	reset_qualifier #(
		.HOLD_MCYCLES (`RESET_MCYCLES)
	) reset_qualifier_inst (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.rst_pin_in (rst_pin_in),
		.mcycle_end (mcycle_end),
		.rst_valid  (rst_valid)
	);

	assign in_reset  = rst_valid;
	// oscillator gate
	// A rising reset pin restarts the oscillator, otherwise the machine
	// cycles that qualify the reset could never be counted in power-down.
	assign osc_on = (mode_nxt != rst_lp_pkg::MODE_PDOWN) || in_reset ||
	                pin_sync2_r;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_sync1_r <= 1'b0;
			pin_sync2_r <= 1'b0;
		end else begin
			pin_sync1_r <= rst_pin_in;
			pin_sync2_r <= pin_sync1_r;
		end
	end
	assign idle_req  = power_control_register[`PCTL_IDLE_BIT];
	assign pdown_req = power_control_register[`PCTL_PDOWN_BIT];

	// Power-down wins when software sets both bits, as it saves more.
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			rst_lp_pkg::MODE_RUN: begin
				if (instr_done && pdown_req)
					mode_nxt = rst_lp_pkg::MODE_PDOWN;
				else if (instr_done && idle_req)
					mode_nxt = rst_lp_pkg::MODE_IDLE;
			end
			rst_lp_pkg::MODE_IDLE: begin
				if (irq_pending)
					mode_nxt = rst_lp_pkg::MODE_RUN;
			end
			rst_lp_pkg::MODE_PDOWN: begin
				mode_nxt = rst_lp_pkg::MODE_PDOWN;
			end
			default: mode_nxt = rst_lp_pkg::MODE_RUN;
		endcase
		if (in_reset)
			mode_nxt = rst_lp_pkg::MODE_RUN;
	end

	assign low_power   = (mode_r != rst_lp_pkg::MODE_RUN);
	assign pc_internal = ({1'b0, pc} < `INTERNAL_CODE_LIMIT);
	assign wdt_active  = (wdt_cnt_r != 5'h00);
	assign wdt_cnt_nxt = watchdog_overflow ?
	                     5'(`WDT_PULSE_MCYCLES * `OSC_PER_MCYCLE) :
	                     wdt_active ? wdt_cnt_r - 5'h01 : 5'h00;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mode_r <= rst_lp_pkg::MODE_RUN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ea_sync1_r <= 1'b0;
			ea_sync2_r <= 1'b0;
			ea_latch_r <= 1'b0;
		end else begin
			ea_sync1_r <= ext_access_in;
			ea_sync2_r <= ea_sync1_r;
			if (in_reset)
				ea_latch_r <= ea_sync2_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wdt_cnt_r   <= 5'h00;
			rst_pin_out <= 1'b0;
			rst_pin_oe  <= 1'b0;
		end else begin
			wdt_cnt_r   <= wdt_cnt_nxt;
			rst_pin_out <= (wdt_cnt_nxt != 5'h00);
			rst_pin_oe  <= (wdt_cnt_nxt != 5'h00);
		end
	end

	// Registered outputs; clock gates freeze state rather than clear it.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			core_reset             <= 1'b1;
			cpu_run                <= 1'b0;
			periph_run             <= 1'b0;
			osc_run                <= 1'b1;
			phase_clk              <= 1'b0;
			external_access_select <= 1'b0;
			fetch_internal         <= 1'b0;
			code_read_allow        <= 1'b0;
			readout_refused        <= 1'b0;
			irq_vector_take        <= 1'b0;
			address_latch_strobe   <= 1'b1;
			program_store_strobe   <= 1'b1;
			port0_oe               <= 1'b0;
			port0_hold             <= 1'b0;
			port2_addr_sel         <= 1'b0;
			pulse_width_out0       <= `PWM_HOLD_LVL;
			pulse_width_out1       <= `PWM_HOLD_LVL;
			mode                   <= rst_lp_pkg::MODE_RUN;
		end else begin
			core_reset <= in_reset;
			mode       <= mode_nxt;
			phase_clk  <= phase_w;
			cpu_run    <= (mode_nxt == rst_lp_pkg::MODE_RUN) && !in_reset;
			periph_run <= (mode_nxt != rst_lp_pkg::MODE_PDOWN);
			osc_run    <= osc_on;
			external_access_select <= ea_latch_r;
			fetch_internal <= ea_latch_r && pc_internal;
			irq_vector_take <= (mode_r == rst_lp_pkg::MODE_IDLE) &&
			                   irq_pending && !in_reset;
			code_read_allow <= code_read_instr &&
			                   !(CODE_PROTECT && fetch_external &&
			                     ea_latch_r);
			readout_refused <= CODE_PROTECT &&
			                   (test_read_req ||
			                    (code_read_instr && fetch_external &&
			                     ea_latch_r));
			case (mode_nxt)
				rst_lp_pkg::MODE_IDLE: begin
					address_latch_strobe <= `IDLE_STROBE_LVL;
					program_store_strobe <= `IDLE_STROBE_LVL;
					port0_oe             <= ea_latch_r;
					port0_hold           <= 1'b1;
					port2_addr_sel       <= !ea_latch_r;
					pulse_width_out0     <= `PWM_HOLD_LVL;
					pulse_width_out1     <= `PWM_HOLD_LVL;
				end
				rst_lp_pkg::MODE_PDOWN: begin
					address_latch_strobe <= `PDOWN_STROBE_LVL;
					program_store_strobe <= `PDOWN_STROBE_LVL;
					port0_oe             <= ea_latch_r;
					port0_hold           <= 1'b1;
					port2_addr_sel       <= 1'b0;
					pulse_width_out0     <= `PWM_HOLD_LVL;
					pulse_width_out1     <= `PWM_HOLD_LVL;
				end
				default: begin
					address_latch_strobe <= core_ale;
					program_store_strobe <= core_program_store_strobe;
					port0_oe             <= 1'b1;
					port0_hold           <= 1'b0;
					port2_addr_sel       <= !ea_latch_r;
					pulse_width_out0     <= core_pwm0;
					pulse_width_out1     <= core_pwm1;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

/* File: design/rst_lp_defs.svh */
/*
 * Timing counts, mode-bit positions and pin levels for the reset and
 * low-power controller.
 * Assumes inclusion by bare name from design files and the assertion file.
 */
`ifndef RST_LP_DEFS_SVH
`define RST_LP_DEFS_SVH

// Oscillator periods in one machine cycle.
`define OSC_PER_MCYCLE        12
// Machine cycles that the reset pin must stay high to be accepted.
`define RESET_MCYCLES         2
// Internal code space ends at this program counter value.
`define INTERNAL_CODE_LIMIT   17'h02000
// Power control register field positions.
`define PCTL_IDLE_BIT         0
`define PCTL_PDOWN_BIT        1
// Width of the watchdog reset pulse driven out, in machine cycles.
`define WDT_PULSE_MCYCLES     2
// Strobe and PWM pin levels held in the two low-power modes.
`define IDLE_STROBE_LVL       1'b1
`define PDOWN_STROBE_LVL      1'b0
`define PWM_HOLD_LVL          1'b1

`endif

/* File: design/rst_lp_pkg.sv */
/*
 * Types shared by the reset and low-power controller.
 * Assumes the defs header is compiled alongside.
 */
package rst_lp_pkg;
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_PDOWN
	} lp_mode_t;
endpackage

/* File: design/osc_half_divider.sv */
/*
 * Divide-by-two stage for the oscillator clock and a phase counter that
 * marks the last oscillator period of each machine cycle.
 * Assumes sys_clk is the oscillator input clock and the gate stops it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rst_lp_defs.svh"

module osc_half_divider #(
	parameter int PER_MCYCLE = `OSC_PER_MCYCLE
) (
	input  wire logic sys_clk,   // oscillator clock
	input  wire logic rst_b,     // synchronous reset, active low
	input  wire logic osc_run,   // low freezes the divider
	output logic      phase_clk, // divided-by-two internal phase
	output logic      mcycle_end // pulse at the end of a machine cycle
);
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	wire        cnt_wrap;

	assign cnt_wrap = (cnt_r == 4'(PER_MCYCLE - 1));
	assign cnt_nxt  = cnt_wrap ? 4'h0 : cnt_r + 4'h1;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			phase_clk  <= 1'b0;
			cnt_r      <= 4'h0;
			mcycle_end <= 1'b0;
		end else if (osc_run) begin
			phase_clk  <= ~phase_clk;
			cnt_r      <= cnt_nxt;
			mcycle_end <= cnt_wrap;
		end else begin
			mcycle_end <= 1'b0;
		end
	end
endmodule

`default_nettype wire

/* File: design/reset_qualifier.sv */
/*
 * Synchronises the reset pin and accepts a reset only after it has been
 * high across the required number of machine-cycle boundaries.
 * Assumes mcycle_end is a one-cycle pulse from the oscillator divider.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rst_lp_defs.svh"

module reset_qualifier #(
	parameter int HOLD_MCYCLES = `RESET_MCYCLES
) (
	input  wire logic sys_clk,    // oscillator clock
	input  wire logic rst_b,      // synchronous reset, active low
	input  wire logic rst_pin_in, // reset pin level, high asserts
	input  wire logic mcycle_end, // machine cycle boundary pulse
	output logic      rst_valid   // reset accepted, level
);
	logic       sync1_r;
	logic       sync2_r;
	logic [2:0] held_r;
	logic [2:0] held_nxt;
	wire        held_full;

	assign held_full = (held_r >= 3'(HOLD_MCYCLES));
	assign held_nxt  = !sync2_r ? 3'h0 :
	                   (mcycle_end && !held_full) ? held_r + 3'h1 : held_r;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sync1_r   <= 1'b0;
			sync2_r   <= 1'b0;
			held_r    <= 3'h0;
			rst_valid <= 1'b0;
		end else begin
			sync1_r   <= rst_pin_in;
			sync2_r   <= sync1_r;
			held_r    <= held_nxt;
			rst_valid <= sync2_r && (held_nxt >= 3'(HOLD_MCYCLES));
		end
	end
endmodule

`default_nettype wire

/* File: tb/reset_source_model.sv */
/*
 * External reset circuit: drives the reset pin high for a set number of
 * clocks and merges the device's own watchdog drive onto the same pin.
 * Assumes start is a one-cycle request on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_source_model (
	input  wire logic       sys_clk, // oscillator clock
	input  wire logic       start,   // begin a reset pulse
	input  wire logic [7:0] len,     // pulse length in clocks
	input  wire logic       dev_out, // device pin drive level
	input  wire logic       dev_oe,  // device pin drive enable
	output logic            rst_pin  // resolved pin level
);
	logic [7:0] cnt_r = 8'h00;

	always_ff @(posedge sys_clk) begin
		if (start)
			cnt_r <= len;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
	// The pin has a pull-down, so a released pin reads low.
	assign rst_pin = (cnt_r != 8'h00) | (dev_oe & dev_out);
endmodule

`default_nettype wire

/* File: tb/reset_lowpower_mode_control_asserts.sv */
/*
 * Concurrent checks on the reset and low-power controller's ports.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rst_lp_defs.svh"

module reset_lowpower_mode_control_asserts #(
	parameter logic CODE_PROTECT = 1'b0,
	parameter int   PC_WIDTH     = 16
) (
	input wire logic                sys_clk,                // clock
	input wire logic                rst_b,                  // reset
	input wire logic                rst_pin_out,            // pin drive
	input wire logic                rst_pin_oe,             // pin enable
	input wire logic [7:0]          power_control_register, // mode bits
	input wire logic                instr_done,             // retired
	input wire logic                irq_pending,            // interrupt
	input wire logic                watchdog_overflow,      // watchdog
	input wire logic [PC_WIDTH-1:0] pc,                     // counter
	input wire logic                test_read_req,          // readout
	input wire logic                core_reset,             // core reset
	input wire logic                cpu_run,                // core gate
	input wire logic                periph_run,             // periph gate
	input wire logic                osc_run,                // oscillator
	input wire logic                phase_clk,              // phase
	input wire logic                external_access_select, // latched
	input wire logic                fetch_internal,         // fetch
	input wire logic                readout_refused,        // refused
	input wire logic                irq_vector_take,        // wake
	input wire logic                address_latch_strobe,   // strobe
	input wire logic                program_store_strobe,   // strobe
	input wire logic                pulse_width_out0,       // pwm
	input wire logic                pulse_width_out1,       // pwm
	input wire rst_lp_pkg::lp_mode_t mode                   // mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	phase_toggle_a: assert property (
		osc_run && $past(rst_b) |=> phase_clk != $past(phase_clk))
		else $error("phase did not toggle");
	idle_entry_a: assert property (
		mode == rst_lp_pkg::MODE_RUN && !core_reset && instr_done &&
		power_control_register[1:0] == 2'h1 |=>
		mode == rst_lp_pkg::MODE_IDLE && !cpu_run && periph_run)
		else $error("idle entry wrong");
	pdown_entry_a: assert property (
		mode == rst_lp_pkg::MODE_RUN && !core_reset && instr_done &&
		power_control_register[1] |=>
		mode == rst_lp_pkg::MODE_PDOWN && !osc_run && !cpu_run)
		else $error("power-down entry wrong");
	idle_pins_a: assert property (
		mode == rst_lp_pkg::MODE_IDLE |-> address_latch_strobe &&
		program_store_strobe && pulse_width_out0 && pulse_width_out1)
		else $error("idle pin levels wrong");
	pdown_pins_a: assert property (
		mode == rst_lp_pkg::MODE_PDOWN |-> !address_latch_strobe &&
		!program_store_strobe && pulse_width_out0 && pulse_width_out1)
		else $error("power-down pin levels wrong");
	pdown_stay_a: assert property (
		mode == rst_lp_pkg::MODE_PDOWN && !core_reset |=>
		mode == rst_lp_pkg::MODE_PDOWN || core_reset)
		else $error("power-down left without reset");
	idle_wake_a: assert property (
		mode == rst_lp_pkg::MODE_IDLE && irq_pending && !core_reset |=>
		mode == rst_lp_pkg::MODE_RUN && cpu_run && irq_vector_take
		##1 !irq_vector_take)
		else $error("idle wake wrong");
	ea_hold_a: assert property (
		!core_reset |=> core_reset || $stable(external_access_select))
		else $error("access select moved outside reset");
	fetch_sel_a: assert property (
		!core_reset |=> fetch_internal == ($past(external_access_select)
		&& $past(pc) < `INTERNAL_CODE_LIMIT))
		else $error("fetch selection wrong");
	wdt_pulse_a: assert property (
		watchdog_overflow && !rst_pin_oe |=> (rst_pin_oe && rst_pin_out)[*8])
		else $error("watchdog pulse missing");
	refuse_a: assert property (
		test_read_req |=> readout_refused == CODE_PROTECT)
		else $error("readout refusal wrong");
endmodule

`default_nettype wire

/* File: tb/reset_lowpower_mode_control_test.sv */
/*
 * Self-checking bench for the reset and low-power controller.
 * Assumes the design files and the reset source model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_lowpower_mode_control_test;
	logic sys_clk = 1'b0, rst_b = 1'b0, rst_pin_in, rst_pin_out, rst_pin_oe;
	logic ext_access_in = 1'b0, instr_done = 1'b0, irq_pending = 1'b0;
	logic watchdog_overflow = 1'b0, code_read_instr = 1'b0;
	logic fetch_external = 1'b0, test_read_req = 1'b0, start = 1'b0;
	logic core_ale = 1'b0, core_program_store_strobe = 1'b0, core_pwm0 = 1'b0;
	logic core_pwm1 = 1'b0;
	logic [7:0] power_control_register = 8'h00;
	logic [7:0] len = 8'h28;
	logic [15:0] pc = 16'h0000;
	logic core_reset, cpu_run, periph_run, osc_run, phase_clk, fetch_internal;
	logic external_access_select, code_read_allow, readout_refused;
	logic irq_vector_take, address_latch_strobe, program_store_strobe;
	logic port0_oe, port0_hold, port2_addr_sel;
	logic pulse_width_out0, pulse_width_out1;
	rst_lp_pkg::lp_mode_t mode;
	int failures = 0, compares = 0;

	always #5 sys_clk = ~sys_clk;

	reset_source_model reset_source_model_inst (.sys_clk, .start,
		.len(len), .dev_out(rst_pin_out), .dev_oe(rst_pin_oe),
		.rst_pin(rst_pin_in));
	reset_lowpower_mode_control #(.CODE_PROTECT(1'b1), .PC_WIDTH(16))
		reset_lowpower_mode_control_inst (.*);

	task automatic tally_and_finish;
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic wait_reset(input logic lvl);
		for (int i = 0; i < 400 && core_reset !== lvl; i++)
			tick(1);
		if (core_reset !== lvl) begin
			failures++;
			$display("mismatch at %0t: reset wait ran out", $time);
			tally_and_finish();
		end
	endtask

	// A forty-clock pin reset, always long enough to be accepted.
	task automatic pin_reset;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		wait_reset(1'b1);
	endtask

	task automatic enter_mode(input logic [7:0] bits);
		power_control_register = bits;
		instr_done = 1'b1;
		tick(1);
		instr_done = 1'b0;
	endtask

	task automatic t_reset_latch;
		ext_access_in = 1'b1;
		pin_reset();
		wait_reset(1'b0);
		check(external_access_select, 1'b1);
		ext_access_in = 1'b0;
		pc = 16'h1fff;
		tick(30);
		check(external_access_select, 1'b1);
		check(fetch_internal, 1'b1);
		pc = 16'h2000;
		tick(2);
		check(fetch_internal, 1'b0);
		// Ten clocks cannot span two machine-cycle boundaries.
		watchdog_overflow = 1'b0;
		force_short();
	endtask

	task automatic force_short;
		len = 8'h0a;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(60);
		check(core_reset, 1'b0);
		len = 8'h28;
		wait_reset(1'b0);
	endtask

	task automatic t_idle;
		enter_mode(8'h01);
		check(8'(mode), 8'(rst_lp_pkg::MODE_IDLE));
		check({address_latch_strobe, program_store_strobe}, 8'h03);
		check({pulse_width_out0, pulse_width_out1}, 8'h03);
		check({cpu_run, periph_run}, 8'h01);
		check({port0_oe, port0_hold, port2_addr_sel}, 8'h06);
		tick(6);
		check(8'(mode), 8'(rst_lp_pkg::MODE_IDLE));
		irq_pending = 1'b1;
		tick(1);
		irq_pending = 1'b0;
		check(8'(mode), 8'(rst_lp_pkg::MODE_RUN));
		check(irq_vector_take, 1'b1);
		tick(1);
		check(irq_vector_take, 1'b0);
	endtask

	task automatic t_pdown;
		core_ale = 1'b1;
		core_program_store_strobe = 1'b1;
		enter_mode(8'h03);
		check(8'(mode), 8'(rst_lp_pkg::MODE_PDOWN));
		check({address_latch_strobe, program_store_strobe}, 8'h00);
		check({pulse_width_out0, pulse_width_out1}, 8'h03);
		check(osc_run, 1'b0);
		check({port0_oe, port0_hold, port2_addr_sel}, 8'h06);
		irq_pending = 1'b1;
		tick(10);
		irq_pending = 1'b0;
		check(8'(mode), 8'(rst_lp_pkg::MODE_PDOWN));
		power_control_register = 8'h00;
		pin_reset();
		check(8'(mode), 8'(rst_lp_pkg::MODE_RUN));
		check(osc_run, 1'b1);
		wait_reset(1'b0);
	endtask

	task automatic t_idle_reset;
		enter_mode(8'h01);
		power_control_register = 8'h00;
		pin_reset();
		check(8'(mode), 8'(rst_lp_pkg::MODE_RUN));
		check(cpu_run, 1'b0);
		wait_reset(1'b0);
	endtask

	task automatic t_watchdog;
		int n;
		n = 0;
		watchdog_overflow = 1'b1;
		tick(1);
		watchdog_overflow = 1'b0;
		while (rst_pin_oe === 1'b1 && n < 100) begin
			n++;
			tick(1);
		end
		check(8'(n), 8'h18);
		wait_reset(1'b0);
	endtask

	task automatic t_protect;
		test_read_req = 1'b1;
		tick(1);
		check(readout_refused, 1'b1);
		test_read_req = 1'b0;
		tick(1);
		check(code_read_allow, 1'b0);
		code_read_instr = 1'b1;
		tick(1);
		check(code_read_allow, 1'b1);
		check(readout_refused, 1'b0);
		code_read_instr = 1'b0;
	endtask

	initial begin
		tick(8);
		rst_b = 1'b1;
		tick(2);
		t_reset_latch();
		t_idle();
		t_pdown();
		t_idle_reset();
		t_protect();
		t_watchdog();
		tally_and_finish();
	end
endmodule

bind reset_lowpower_mode_control reset_lowpower_mode_control_asserts #(
	.CODE_PROTECT(CODE_PROTECT), .PC_WIDTH(PC_WIDTH))
	reset_lowpower_mode_control_asserts_inst (.sys_clk,
	.rst_b, .rst_pin_out, .rst_pin_oe, .power_control_register,
	.instr_done, .irq_pending, .watchdog_overflow, .pc, .test_read_req,
	.core_reset, .cpu_run, .periph_run, .osc_run, .phase_clk,
	.external_access_select, .fetch_internal, .readout_refused,
	.irq_vector_take, .address_latch_strobe, .program_store_strobe,
	.pulse_width_out0, .pulse_width_out1, .mode);

`default_nettype wire
